// file: logic/ctl_delay.v
// restart delay counter
`timescale 1ns/1ps
module ctl_delay #(
  parameter CYCLES = 4000,
  parameter W = 16
) (
  input wire aclk,
  input wire aresetn,
  input wire start,
  output wire busy
);
  reg [W-1:0] count;
  always @(posedge aclk) begin
    if (!aresetn) begin
      count <= {W{1'b0}};
    end else if (start) begin
      count <= CYCLES[W-1:0];
    end else if (count != {W{1'b0}}) begin
      count <= count - {{(W-1){1'b0}}, 1'b1};
    end
  end
  assign busy = (count != {W{1'b0}});
endmodule // ctl_delay

// file: logic/ctl_sync.v
// two-flop synchroniser for one pin
`timescale 1ns/1ps
module ctl_sync #(
  parameter RESET_VAL = 1'b1
) (
  input wire aclk,
  input wire aresetn,
  input wire d,
  output reg q
);
  reg meta;
  always @(posedge aclk) begin
    if (!aresetn) begin
      meta <= RESET_VAL;
      q <= RESET_VAL;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule // ctl_sync

// file: logic/ctl_trap.v
// trap, wait and stop control with an axi4-lite register slave
`timescale 1ns/1ps
`include "ctl_defs.vh"
module ctl_trap #(
  parameter RESTART_CYCLES = `CTL_RESTART_CYC,
  parameter NFLAGS = 8
) (
  input wire aclk,
  input wire aresetn,
  input wire por_n,
  input wire [31:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [31:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire maskable_request_pin_n,
  input wire nonmaskable_request_pin_n,
  input wire reset_pin_n,
  input wire edge_mode,
  input wire [NFLAGS-1:0] periph_event,
  input wire [NFLAGS-1:0] periph_enable,
  input wire [NFLAGS-1:0] flag_clear,
  input wire op_done,
  input wire illegal_op,
  input wire soft_trap_op,
  input wire idle_until_event_op,
  input wire stop_op,
  input wire [15:0] op_first_addr,
  input wire [15:0] next_pc,
  input wire [15:0] sp,
  output reg irq_to_core,
  output reg nonmaskable_request_pin_to_core,
  output reg trap_to_core,
  output reg [15:0] stacked_return,
  output reg stack_req,
  output reg vector_req,
  output reg core_halt,
  output reg clocks_halted,
  output reg wait_read,
  output reg [15:0] wait_read_addr,
  output reg timer_halt,
  output reg converter_power_on,
  output reg serial_periph_on,
  output reg tx_on,
  output reg rx_on,
  output reg [NFLAGS-1:0] periph_flag,
  output reg reset_wake
);
  localparam DW = 16;
  reg [8:0] ctrl;
  reg [2:0] state;
  reg aw_held, w_held;
  reg [31:0] aw_addr, w_data;
  reg soft_busy, edge_pend, pin_prev, start_delay, por_seen;
  wire irq_s, nonmaskable_request_pin_s, rst_s, busy;
  wire mask_i = ctrl[`CTL_BIT_I];
  wire mask_x = ctrl[`CTL_BIT_X];
  ctl_sync #(.RESET_VAL(1'b1)) u_si (.aclk(aclk), .aresetn(aresetn),
    .d(maskable_request_pin_n), .q(irq_s));
  ctl_sync #(.RESET_VAL(1'b1)) u_sx (.aclk(aclk), .aresetn(aresetn),
    .d(nonmaskable_request_pin_n), .q(nonmaskable_request_pin_s));
  ctl_sync #(.RESET_VAL(1'b1)) u_sr (.aclk(aclk), .aresetn(aresetn),
    .d(reset_pin_n), .q(rst_s));
  ctl_delay #(.CYCLES(RESTART_CYCLES), .W(DW)) u_dly (.aclk(aclk),
    .aresetn(aresetn), .start(start_delay), .busy(busy));
  // maskable source: low level by default, edge only when selected
  wire irq_level = edge_mode ? edge_pend : ~irq_s;
  wire any_flag = |(periph_flag & periph_enable);
  wire irq_any = (irq_level | any_flag) & ~mask_i;
  wire nonmaskable_request_pin_any = ~nonmaskable_request_pin_s & ~mask_x;
  // axi write path: address and data accepted in either order
  assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready = ~w_held & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  wire aw_now = aw_held | s_axi_awvalid;
  wire w_now = w_held | s_axi_wvalid;
  wire [31:0] wa = aw_held ? aw_addr : s_axi_awaddr;
  wire [31:0] wd = w_held ? w_data : s_axi_wdata;
  wire do_write = aw_now & w_now & ~s_axi_bvalid;
  wire wr_ctrl = do_write & (wa == `CTL_ADDR_CTRL) & s_axi_wstrb[0];
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 32'h00000000;
      w_data <= 32'h00000000;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `CTL_RESP_OKAY;
    end else begin
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wa == `CTL_ADDR_CTRL) ? `CTL_RESP_OKAY : `CTL_RESP_DECERR;
      end else begin
        if (s_axi_awvalid & s_axi_awready) begin
          aw_held <= 1'b1;
          aw_addr <= s_axi_awaddr;
        end
        if (s_axi_wvalid & s_axi_wready) begin
          w_held <= 1'b1;
          w_data <= s_axi_wdata;
        end
        if (s_axi_bvalid & s_axi_bready)
          s_axi_bvalid <= 1'b0;
      end
    end
  end
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `CTL_RESP_OKAY;
    end else if (s_axi_arvalid & s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `CTL_RESP_OKAY;
      if (s_axi_araddr == `CTL_ADDR_CTRL) begin
        s_axi_rdata <= {23'h000000, ctrl};
      end else if (s_axi_araddr == `CTL_ADDR_STAT) begin
        s_axi_rdata <= {25'h0000000, busy, clocks_halted, core_halt, state, soft_busy};
      end else if (s_axi_araddr == `CTL_ADDR_PEND) begin
        s_axi_rdata <= {{(32-NFLAGS){1'b0}}, periph_flag};
      end else begin
        s_axi_rdata <= 32'h00000000;
        s_axi_rresp <= `CTL_RESP_DECERR;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
  // peripheral flags: set wins over clear
  always @(posedge aclk) begin
    if (!aresetn)
      periph_flag <= {NFLAGS{1'b0}};
    else
      periph_flag <= (periph_flag & ~flag_clear) | periph_event;
  end
  // edge capture on the maskable pin; cleared when the vector is fetched
  always @(posedge aclk) begin
    if (!aresetn) begin
      pin_prev <= 1'b1;
      edge_pend <= 1'b0;
    end else begin
      pin_prev <= irq_s;
      if (edge_mode & pin_prev & ~irq_s)
        edge_pend <= 1'b1;
      else if (vector_req & ~nonmaskable_request_pin_to_core)
        edge_pend <= 1'b0;
    end
  end
  // a stale edge must not wake the core once level mode is back
  wire wake_irq = ~irq_s | (edge_mode & edge_pend);
  wire wake = (wake_irq & ~mask_i) | ~nonmaskable_request_pin_s | ~rst_s;
  wire wait_wake = irq_any | nonmaskable_request_pin_any | (any_flag & ~mask_i);
  // power-on delay latched after release; a running reset skips it
  always @(posedge aclk) begin
    if (!aresetn) begin
      por_seen <= 1'b0;
      start_delay <= 1'b0;
    end else begin
      por_seen <= 1'b1;
      start_delay <= 1'b0;
      if (!por_seen & !por_n)
        start_delay <= 1'b1;
      // a reset wake starts the delay whatever the delay bit holds, so it always waits
      if (state == `CTL_ST_STOP && wake && (ctrl[`CTL_BIT_DLY] | ~rst_s))
        start_delay <= 1'b1;
    end
  end
  always @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= `CTL_CTRL_RESET;
      state <= `CTL_ST_RUN;
      soft_busy <= 1'b0;
      stack_req <= 1'b0;
      vector_req <= 1'b0;
      trap_to_core <= 1'b0;
      stacked_return <= 16'h0000;
      reset_wake <= 1'b0;
      nonmaskable_request_pin_to_core <= 1'b0;
    end else begin
      stack_req <= 1'b0;
      vector_req <= 1'b0;
      trap_to_core <= 1'b0;
      reset_wake <= 1'b0;
      if (wr_ctrl) begin
        ctrl <= wd[8:0] & `CTL_CTRL_MASK;
        ctrl[`CTL_BIT_X] <= mask_x & wd[`CTL_BIT_X]; // x cannot be set again once clear
      end
      case (state)
        `CTL_ST_RUN: begin
          if (illegal_op) begin
            trap_to_core <= 1'b1;
            stacked_return <= op_first_addr;
            state <= `CTL_ST_STACK;
          end else if (soft_trap_op) begin
            soft_busy <= 1'b1;
            stacked_return <= next_pc;
            state <= `CTL_ST_STACK;
          end else if (idle_until_event_op) begin
            stacked_return <= next_pc;
            stack_req <= 1'b1;
            state <= `CTL_ST_WAIT;
          end else if (stop_op & ~ctrl[`CTL_BIT_S]) begin
            state <= `CTL_ST_STOP;
          end else if (op_done & ~soft_busy & (nonmaskable_request_pin_any | irq_any)) begin
            nonmaskable_request_pin_to_core <= nonmaskable_request_pin_any;
            stacked_return <= next_pc;
            state <= `CTL_ST_STACK;
          end
        end
        `CTL_ST_WAIT: begin
          if (wait_wake) begin
            nonmaskable_request_pin_to_core <= nonmaskable_request_pin_any;
            state <= `CTL_ST_VECTOR;
          end
        end
        `CTL_ST_STOP: begin
          if (wake) begin
            reset_wake <= ~rst_s;
            nonmaskable_request_pin_to_core <= ~nonmaskable_request_pin_s & ~mask_x & rst_s;
            // a reset wake restores the defaults, delay enable included
            if (!rst_s)
              ctrl <= `CTL_CTRL_RESET;
            state <= `CTL_ST_DELAY;
          end
        end
        `CTL_ST_DELAY: begin
          if (!busy & !start_delay) begin
            // masked nonmaskable wake resumes after the stop op
            if (nonmaskable_request_pin_to_core | (wake_irq & ~mask_i))
              state <= `CTL_ST_STACK;
            else
              state <= `CTL_ST_RUN;
          end
        end
        `CTL_ST_STACK: begin
          stack_req <= 1'b1;
          state <= `CTL_ST_VECTOR;
        end
        default: begin
          vector_req <= 1'b1;
          soft_busy <= 1'b0;
          ctrl[`CTL_BIT_I] <= 1'b1;
          if (nonmaskable_request_pin_to_core)
            ctrl[`CTL_BIT_X] <= 1'b1;
          nonmaskable_request_pin_to_core <= 1'b0;
          state <= `CTL_ST_RUN;
        end
      endcase
    end
  end
  // outputs that follow mode and configuration
  always @(posedge aclk) begin
    if (!aresetn) begin
      irq_to_core <= 1'b0;
      core_halt <= 1'b0;
      clocks_halted <= 1'b0;
      wait_read <= 1'b0;
      wait_read_addr <= 16'h0000;
      timer_halt <= 1'b0;
      converter_power_on <= 1'b0;
      serial_periph_on <= 1'b0;
      tx_on <= 1'b0;
      rx_on <= 1'b0;
    end else begin
      irq_to_core <= irq_any;
      core_halt <= (state == `CTL_ST_WAIT) | (state == `CTL_ST_STOP) |
        (state == `CTL_ST_DELAY) | busy;
      clocks_halted <= (state == `CTL_ST_STOP);
      wait_read <= (state == `CTL_ST_WAIT);
      wait_read_addr <= sp - `CTL_CCR_OFFSET;
      timer_halt <= (state == `CTL_ST_WAIT) & mask_i & ctrl[`CTL_BIT_NOWD];
      converter_power_on <= ctrl[`CTL_BIT_CONV];
      serial_periph_on <= ctrl[`CTL_BIT_SPI];
      tx_on <= ctrl[`CTL_BIT_TX];
      rx_on <= ctrl[`CTL_BIT_RX];
    end
  end
endmodule // ctl_trap

// file: pkg/ctl_defs.vh
// constants for the trap and low-power control block
`ifndef CTL_DEFS_VH
`define CTL_DEFS_VH
`define CTL_ADDR_CTRL 32'h00000000
`define CTL_ADDR_STAT 32'h00000004
`define CTL_ADDR_WAKE 32'h00000008
`define CTL_ADDR_PEND 32'h0000000C
`define CTL_BIT_I 0
`define CTL_BIT_X 1
`define CTL_BIT_S 2
`define CTL_BIT_DLY 3
`define CTL_BIT_NOWD 4
`define CTL_BIT_CONV 5
`define CTL_BIT_SPI 6
`define CTL_BIT_TX 7
`define CTL_BIT_RX 8
`define CTL_CTRL_RESET 9'h00F
`define CTL_CTRL_MASK 9'h1FF
`define CTL_RESP_OKAY 2'h0
`define CTL_RESP_DECERR 2'h3
`define CTL_RESTART_NS 20000
`define CTL_CLK_NS 5
`define CTL_RESTART_CYC ((`CTL_RESTART_NS + `CTL_CLK_NS - 1) / `CTL_CLK_NS)
`define CTL_CCR_OFFSET 16'h0008
`define CTL_ST_RUN 3'h0
`define CTL_ST_WAIT 3'h1
`define CTL_ST_STOP 3'h2
`define CTL_ST_DELAY 3'h3
`define CTL_ST_STACK 3'h4
`define CTL_ST_VECTOR 3'h5
`endif

// file: testbench/ctl_pin_model.sv
// external request pins and reset circuit
`timescale 1ns/1ps
module ctl_pin_model (
  input wire aclk,
  input wire [1:0] irq_src,
  input wire nonmaskable_request_pin_src,
  input wire rst_src,
  output logic maskable_request_pin_n = 1'b1,
  output logic nonmaskable_request_pin_n = 1'b1,
  output logic reset_pin_n = 1'b1
);
  // open-drain sources; a released line returns high through its pull-up
  always @(posedge aclk) begin
    maskable_request_pin_n <= ~|irq_src;
    nonmaskable_request_pin_n <= ~nonmaskable_request_pin_src;
    reset_pin_n <= ~rst_src;
  end
endmodule // ctl_pin_model

// file: testbench/ctl_trap_sva.sv
// checker for the trap and low-power control ports
`timescale 1ns/1ps
module ctl_trap_sva #(
  parameter NFLAGS = 8
) (
  input wire aclk,
  input wire aresetn,
  input wire illegal_op,
  input wire trap_to_core,
  input wire timer_halt,
  input wire core_halt,
  input wire clocks_halted,
  input wire nonmaskable_request_pin_n,
  input wire [NFLAGS-1:0] periph_event,
  input wire [NFLAGS-1:0] flag_clear,
  input wire [NFLAGS-1:0] periph_flag
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // pin passes a two-flop synchroniser, so it must stay low a while
  sequence s_x_low;
    clocks_halted && !nonmaskable_request_pin_n ##1 !nonmaskable_request_pin_n [*2];
  endsequence
  sequence s_clr;
    flag_clear[0] && !periph_event[0];
  endsequence
  property p_trap; illegal_op |-> ##[1:4] trap_to_core; endproperty
  a_trap: assert property (p_trap) else $error("no trap");
  property p_trap_pulse; trap_to_core |=> !trap_to_core; endproperty
  a_trap_pulse: assert property (p_trap_pulse) else $error("trap too long");
  property p_timer; timer_halt |-> core_halt || $past(core_halt); endproperty
  a_timer: assert property (p_timer) else $error("timer halt outside wait");
  property p_stop; clocks_halted |-> core_halt || $past(core_halt); endproperty
  a_stop: assert property (p_stop) else $error("clocks off, core on");
  property p_set; periph_event[0] |=> periph_flag[0]; endproperty
  a_set: assert property (p_set) else $error("flag not set");
  property p_hold; periph_flag[0] && !flag_clear[0] |=> periph_flag[0]; endproperty
  a_hold: assert property (p_hold) else $error("flag lost");
  property p_clr; s_clr |=> !periph_flag[0]; endproperty
  a_clr: assert property (p_clr) else $error("flag not cleared");
  property p_xwake; s_x_low |-> ##[0:20] !clocks_halted; endproperty
  a_xwake: assert property (p_xwake) else $error("no wake on pin");
endmodule // ctl_trap_sva
bind ctl_trap ctl_trap_sva #(.NFLAGS(NFLAGS)) i_sva (.*);

// file: testbench/testbench.sv
// self-checking bench for the trap and low-power control block
`timescale 1ns/1ps
`include "ctl_defs.vh"
module testbench;
  logic aclk = 1'b0, aresetn = 1'b0, por_n = 1'b0, edge_mode = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr, irq_src = '0;
  logic maskable_request_pin_n, nonmaskable_request_pin_n, reset_pin_n;
  logic [7:0] periph_event = '0, periph_enable = 8'h01, flag_clear = '0, periph_flag;
  logic op_done = 1'b0, illegal_op = 1'b0, soft_trap_op = 1'b0;
  logic idle_until_event_op = 1'b0, stop_op = 1'b0;
  logic [15:0] op_first_addr = '0, next_pc = '0, stacked_return, wait_read_addr;
  logic [15:0] sp = 16'h01FF; // handler keeps the stack pointer reloaded
  logic irq_to_core, nonmaskable_request_pin_to_core, trap_to_core, stack_req, vector_req, core_halt;
  logic clocks_halted, wait_read, timer_halt, converter_power_on, serial_periph_on;
  logic tx_on, rx_on, reset_wake, nonmaskable_request_pin_src = 1'b0, rst_src = 1'b0, seen;
  int failures = 0, compares = 0, n, h;
  always #2.5 aclk = ~aclk;
  // short restart delay keeps the run brief
  ctl_trap #(.RESTART_CYCLES(8)) i_dut (.*);
  ctl_pin_model i_pins (.*);
  task chk(input logic [39:0] got, exp, input string msg);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %0t %s", $time, msg);
    end
  endtask
  task tick(input int c);
    repeat (c) @(posedge aclk);
    #1;
  endtask
  task wr(input logic [31:0] a, d);
    logic ta, tw, p, q;
    ta = 1'b0;
    tw = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(ta && tw)) begin
      #1 p = s_axi_awready && s_axi_awvalid;
      q = s_axi_wready && s_axi_wvalid;
      @(posedge aclk);
      if (p) begin
        ta = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (q) begin
        tw = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do begin
      #1 p = s_axi_bvalid;
      rr = s_axi_bresp;
      @(posedge aclk);
    end while (!p);
    #1;
  endtask
  task rdw(input logic [31:0] a);
    logic p;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      #1 p = s_axi_arready;
      @(posedge aclk);
    end while (!p);
    s_axi_arvalid <= 1'b0;
    do begin
      #1 p = s_axi_rvalid;
      rd = s_axi_rdata;
      rr = s_axi_rresp;
      @(posedge aclk);
    end while (!p);
    #1;
  endtask
  task t_regs;
    rdw(`CTL_ADDR_CTRL);
    chk(rd, `CTL_CTRL_RESET, "ctrl reset");
    rdw(`CTL_ADDR_WAKE);
    chk({rr, rd}, {`CTL_RESP_DECERR, 32'h0}, "unmapped");
    wr(`CTL_ADDR_WAKE, 32'h0);
    chk(rr, `CTL_RESP_DECERR, "unmapped write");
    wr(`CTL_ADDR_CTRL, 32'h1F8);
    chk(rr, `CTL_RESP_OKAY, "write response");
    rdw(`CTL_ADDR_CTRL);
    chk(rd, 32'h1F8, "ctrl write");
    chk({converter_power_on, serial_periph_on, tx_on, rx_on}, 4'hF, "enables");
  endtask
  task t_soft;
    for (int k = 0; k < 2; k++) begin
      wr(`CTL_ADDR_CTRL, k ? 32'h1F8 : 32'h1F9);
      next_pc <= 16'h3001 + 16'(k);
      soft_trap_op <= 1'b1;
      tick(1);
      soft_trap_op <= 1'b0;
      seen = 1'b0;
      for (n = 0; !vector_req && n < 10; n++) begin
        seen = seen | stack_req;
        tick(1);
      end
      chk({vector_req, seen, stacked_return}, {2'h3, 16'h3001 + 16'(k)}, "soft trap");
      rdw(`CTL_ADDR_CTRL);
      chk(rd[0], 1, "soft trap mask");
    end
  endtask
  task t_trap;
    for (int k = 0; k < 4; k++) begin
      op_first_addr <= 16'h2000 + 16'(k);
      next_pc <= 16'h2002 + 16'(k);
      illegal_op <= 1'b1;
      tick(1);
      illegal_op <= 1'b0;
      for (n = 0; !trap_to_core && n < 20; n++) tick(1);
      chk(trap_to_core, 1, "trap");
      chk(stacked_return, 16'h2000 + 16'(k), "return address");
      // stacking and vector fetch must finish before the next opcode
      tick(3);
    end
  endtask
  task t_flag;
    wr(`CTL_ADDR_CTRL, 32'h1F8);
    periph_event <= 8'h01;
    tick(1);
    periph_event <= '0;
    tick(3);
    repeat (5) begin
      chk(irq_to_core, 1, "request held");
      tick(1);
    end
    rdw(`CTL_ADDR_PEND);
    chk(rd, 32'h1, "pending flag");
    flag_clear <= 8'h01;
    tick(1);
    flag_clear <= '0;
    tick(3);
    chk({periph_flag[0], irq_to_core}, 0, "request released");
    periph_event <= 8'h01;
    tick(2);
    periph_event <= '0;
    op_done <= 1'b1;
    tick(1);
    op_done <= 1'b0;
    for (n = 0; !vector_req && n < 10; n++) tick(1);
    chk({vector_req, nonmaskable_request_pin_to_core}, 2'h2, "flag serviced");
    flag_clear <= 8'h01;
    tick(1);
    flag_clear <= '0;
    tick(1);
  endtask
  task t_wait;
    wr(`CTL_ADDR_CTRL, 32'h1F9);
    idle_until_event_op <= 1'b1;
    tick(1);
    idle_until_event_op <= 1'b0;
    for (n = 0; !wait_read && n < 20; n++) tick(1);
    chk({core_halt, wait_read, timer_halt, converter_power_on}, 4'hF, "wait");
    chk(wait_read_addr, sp - 16'h0008, "wait address");
    rdw(`CTL_ADDR_STAT);
    chk(rd[4:1], {1'b1, `CTL_ST_WAIT}, "status in wait");
    nonmaskable_request_pin_src <= 1'b1;
    seen = 1'b0;
    for (n = 0; !vector_req && n < 40; n++) begin
      seen = seen | stack_req;
      tick(1);
    end
    nonmaskable_request_pin_src <= 1'b0;
    chk({vector_req, seen}, 2'h2, "wake");
    rdw(`CTL_ADDR_CTRL);
    chk(rd[1:0], 2'h3, "masks set");
  endtask
  task t_stop;
    for (int k = 0; k < 2; k++) begin
      wr(`CTL_ADDR_CTRL, k ? 32'h1F2 : 32'h1FA); // delay off only with interrupt exit
      stop_op <= 1'b1;
      tick(1);
      stop_op <= 1'b0;
      tick(3);
      chk(clocks_halted, 1, "stop");
      nonmaskable_request_pin_src <= (k == 0);
      irq_src <= k ? 2'h1 : 2'h0;
      seen = 1'b0;
      h = 0;
      for (n = 0; n < 30; n++) begin
        seen = seen | vector_req;
        h += (core_halt === 1'b1);
        tick(1);
      end
      nonmaskable_request_pin_src <= 1'b0;
      irq_src <= '0;
      chk({h > 8, seen, clocks_halted}, k ? 3'h2 : 3'h4, "stop exit");
    end
  endtask
  task t_edge;
    edge_mode <= 1'b1;
    wr(`CTL_ADDR_CTRL, 32'h1F2);
    irq_src <= 2'h1;
    tick(1);
    irq_src <= '0;
    tick(6);
    stop_op <= 1'b1;
    tick(1);
    stop_op <= 1'b0;
    seen = 1'b0;
    for (n = 0; !seen && n < 10; n++) begin
      seen = vector_req;
      tick(1);
    end
    chk({seen, clocks_halted}, 2'h2, "edge wake");
    edge_mode <= 1'b0;
  endtask
  task t_stop_rst;
    wr(`CTL_ADDR_CTRL, 32'h1FB);
    stop_op <= 1'b1;
    tick(1);
    stop_op <= 1'b0;
    irq_src <= 2'h2;
    tick(20);
    chk(clocks_halted, 1, "masked pin");
    irq_src <= '0;
    rst_src <= 1'b1;
    seen = 1'b0;
    for (n = 0; !seen && n < 20; n++) begin
      seen = reset_wake;
      tick(1);
    end
    rst_src <= 1'b0;
    chk(seen, 1, "reset wake");
    tick(20);
    rdw(`CTL_ADDR_CTRL);
    chk(rd, `CTL_CTRL_RESET, "ctrl after wake");
    wr(`CTL_ADDR_CTRL, 32'h00F);
    stop_op <= 1'b1;
    tick(1);
    stop_op <= 1'b0;
    tick(8);
    chk(clocks_halted, 0, "stop as nop");
  endtask
  task complete_run;
    $display("failures %0d compares %0d", failures, compares);
    if (failures == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    tick(2);
    aresetn <= 1'b1;
    tick(1);
    por_n <= 1'b1;
    for (n = 0; !core_halt && n < 5; n++) tick(1);
    chk(core_halt, 1, "power-on delay");
    for (n = 0; core_halt && n < 40; n++) tick(1);
    chk(n > 3 && n < 16, 1, "delay length");
    aresetn <= 1'b0;
    tick(2);
    aresetn <= 1'b1;
    tick(3);
    chk(core_halt, 0, "running reset");
    t_regs;
    t_soft;
    t_trap;
    t_flag;
    t_wait;
    t_stop;
    t_edge;
    t_stop_rst;
    complete_run;
  end
  initial begin
    #100000;
    failures++;
    complete_run;
  end
endmodule // testbench
